/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import zsm_pkg::*;
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin \
   miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic run = 1'b0;
   logic cut = 1'b0;
   logic hold = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic sensA, sensB, ack, rel, flt;
   logic [ADDR_W-1:0] adr = '0;
   logic [DATA_W-1:0] wdat = '0;
   logic [DATA_W-1:0] rdat, d;
   logic [15:0] rate, diag;
   int miscompares = 0;
   int cmpCount = 0;
   int tick = 0;
   always #20 core_clk = ~core_clk;
   zsm_sensor_model cams (.core_clk(core_clk), .run(run), .cut(cut),
      .hold(hold), .sensA(sensA), .sensB(sensB));
   zero_speed_monitor #(.GATE_CYCLES(100)) uut (.core_clk(core_clk),
      .reset_n(reset_n), .sensorInputA(sensA), .sensorInputB(sensB),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .standstillRelease(rel), .faultFlag(flt), .actualRateHz(rate),
      .diagWord(diag));
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] v);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      @(posedge core_clk);
      while (ack !== 1'b1) begin
         @(posedge core_clk);
      end
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   task automatic reportAndStop;
      $display("checks %0d miscompares %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // a hang is cut short well past the expected run length
   always @(posedge core_clk) begin
      tick++;
      if (tick == 5000) begin
         miscompares++;
         reportAndStop;
      end
   end
   initial begin
      idle(2);
      reset_n <= 1'b1;
      idle(2);
      bus(1'b0, REG_CFG, '0);
      `CHK("cfg", 32'h0000_0202, d)
      `CHK("arm", DG_WAIT_ARM, diag)
      bus(1'b1, REG_CFG, 32'h0000_3302);
      bus(1'b0, REG_CFG, '0);
      `CHK("limit", 32'h0000_0202, d)
      bus(1'b1, REG_CFG, 32'h0000_0a00);
      bus(1'b1, REG_COIL, 32'h1);
      idle(3);
      `CHK("still", {DG_STILL, 1'b1}, {diag, rel})
      run <= 1'b1;
      idle(300);
      `CHK("trip", {DG_MEASURE, 1'b0}, {diag, rel})
      `CHK("rate", 1'b1, rate >= 16'h000c && rate <= 16'h000d)
      bus(1'b0, REG_RATE, '0);
      `CHK("rrate", 1'b1, d >= 32'h0000_000c && d <= 32'h0000_000d)
      run <= 1'b0;
      idle(300);
      `CHK("auto", 1'b1, rel)
      cut <= 1'b1;
      idle(7);
      `CHK("open", {DG_OPEN, 2'h2}, {diag, flt, rel})
      bus(1'b1, REG_COIL, 32'h0);
      idle(3);
      `CHK("clr", DG_WAIT_ARM, diag)
      bus(1'b1, REG_COIL, 32'h1);
      idle(3);
      `CHK("lowok", 2'h1, {flt, rel})
      cut <= 1'b0;
      bus(1'b1, REG_COIL, 32'h0);
      bus(1'b1, REG_CFG, 32'h0000_0a02);
      bus(1'b1, REG_COIL, 32'h3);
      idle(3);
      `CHK("ackup", DG_ACKSTART, diag)
      bus(1'b1, REG_COIL, 32'h0);
      bus(1'b1, REG_COIL, 32'h1);
      idle(2);
      `CHK("rise", {DG_ACK_RISE, 1'b0}, {diag, rel})
      bus(1'b1, REG_COIL, 32'h3);
      idle(2);
      `CHK("fall", DG_ACK_FALL, diag)
      bus(1'b1, REG_COIL, 32'h1);
      idle(3);
      `CHK("man", 1'b1, rel)
      bus(1'b0, REG_DIAG, '0);
      `CHK("rdiag", {16'h0000, DG_STILL}, d)
      bus(1'b0, REG_STAT, '0);
      `CHK("stat", 32'h0000_0001, d)
      bus(1'b0, 5'h14, '0);
      `CHK("unmap", 32'h0, d)
      hold <= 1'b1;
      run <= 1'b1;
      idle(300);
      `CHK("nopls", {DG_NOPULSE, 2'h2}, {diag, flt, rel})
      run <= 1'b0;
      hold <= 1'b0;
      bus(1'b1, REG_CFG, 32'h0000_0a03);
      idle(3);
      `CHK("gate", {DG_NOGATE, 1'b0}, {diag, rel})
      reportAndStop;
   end
endmodule

/* File: bench/zsm_sensor_model.sv */
`timescale 1ns/1ps
module zsm_sensor_model (
   input wire logic core_clk,
   input wire logic run,
   input wire logic cut,
   input wire logic hold,
   output logic sensA,
   output logic sensB
);
   // four steps of two cycles, cams overlap: never both low
   // one rise per eight cycles, far under the pulse ceiling
   logic [2:0] ph = 3'h0;
   always @(posedge core_clk) begin
      // parks only with both cams high, as a stopped wheel would
      if (run || ph[2:1] != 2'h0) begin
         ph <= ph + 3'h1;
      end
   end
   assign sensA = ~cut & (ph[2:1] != 2'h3);
   // hold pins channel b high, a channel that has stopped pulsing
   assign sensB = ~cut & (hold | (ph[2:1] != 2'h1));
endmodule

/* File: verilog/zero_speed_monitor.sv */
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module zero_speed_monitor
   import zsm_pkg::*;
#(
   parameter int GATE_CYCLES = GATE_CYCLES_DFLT,
   parameter int RATE_W = RATE_W_DFLT
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sensorInputA,
   input wire logic sensorInputB,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [SEL_W-1:0] wb_sel_i,
   input wire logic [DATA_W-1:0] wb_dat_i,
   output logic [DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic standstillRelease,
   output logic faultFlag,
   output logic [RATE_W-1:0] actualRateHz,
   output logic [DIAG_W-1:0] diagWord
);
   localparam int GCW = $clog2(GATE_CYCLES + 1);
   localparam int PW = RATE_W + HYST_W;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ARM = 7'h02,
      ST_RISE = 7'h04,
      ST_FALL = 7'h08,
      ST_MEAS = 7'h10,
      ST_STILL = 7'h20,
      ST_FAULT = 7'h40
   } state_e;

   state_e state_q;
   cfg_s cfg_q;
   coils_s coil_q;
   logic [GCW-1:0] gateCnt_q;
   logic gateTick_q;
   logic rateTick_q;
   logic firstEdge_q;
   logic ackPrev_q;
   logic ackDone_q;
   logic release_q;
   logic fault_q;
   logic [DIAG_W-1:0] faultCode_q;
   logic [DIAG_W-1:0] diag_q;
   logic [RATE_W-1:0] rate_q;
   logic wbAck_q;
   logic [DATA_W-1:0] wbDat_q;

   logic [NUM_CH-1:0] pinVec;
   logic [NUM_CH-1:0] lvl;
   logic [NUM_CH-1:0] rise;
   logic [RATE_W-1:0] chRate [NUM_CH];
   logic [RATE_W-1:0] measRate;
   logic [RATE_W-1:0] absDiff;
   logic [PW-1:0] rateScaled;
   logic [PW-1:0] limitScaled;
   logic clearCnt;
   logic active;
   logic running;
   logic ackRise;
   logic ackFall;
   logic overLimit;
   logic belowHyst;
   logic overRange;
   logic openCkt;
   logic noPulse;
   logic diffRate;
   logic lockstep;
   logic startAck;
   logic faultHit;
   logic [DIAG_W-1:0] codeNow;
   logic wbReq;
   logic wbWr;
   logic [DATA_W-1:0] cfgWord;
   logic [DATA_W-1:0] coilWord;
   logic [DATA_W-1:0] statWord;
   logic [DATA_W-1:0] newCfg;
   logic [DATA_W-1:0] newCoil;

   function automatic logic [DATA_W-1:0] laneMerge(
      input logic [DATA_W-1:0] oldW,
      input logic [DATA_W-1:0] newW,
      input logic [SEL_W-1:0] sel
   );
      logic [DATA_W-1:0] r;
      r = oldW;
      for (int b = 0; b < SEL_W; b++) begin
         if (sel[b]) begin
            r[b*LANE_W +: LANE_W] = newW[b*LANE_W +: LANE_W];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register slave: every access is answered one cycle after it is seen
   assign wbReq = wb_cyc_i & wb_stb_i & ~wbAck_q;
   assign wbWr = wbReq & wb_we_i;

   always_comb begin
      cfgWord = '0;
      cfgWord[CFG_GATE_BIT] = cfg_q.gateNeeded;
      cfgWord[CFG_MODE_LSB +: MODE_W] = cfg_q.mode;
      cfgWord[CFG_LIMIT_LSB +: LIMIT_W] = cfg_q.limit;
      coilWord = '0;
      coilWord[COIL_ARM_BIT] = coil_q.arm;
      coilWord[COIL_ACK_BIT] = coil_q.ack;
      coilWord[COIL_GATE_BIT] = coil_q.gate;
      statWord = '0;
      statWord[STAT_REL_BIT] = release_q;
      statWord[STAT_FLT_BIT] = fault_q;
      statWord[STAT_EDGE_BIT] = firstEdge_q;
   end

   assign newCfg = laneMerge(cfgWord, wb_dat_i, wb_sel_i);
   assign newCoil = laneMerge(coilWord, wb_dat_i, wb_sel_i);

   // out of range limits and the unused mode code are dropped, not clipped
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= CFG_RST;
      end else if (wbWr && wb_adr_i == REG_CFG) begin
         cfg_q.gateNeeded <= newCfg[CFG_GATE_BIT];
         if (newCfg[CFG_MODE_LSB +: MODE_W] inside
             {RS_AUTO, RS_MANUAL, RS_SUPER}) begin
            cfg_q.mode <= restart_e'(newCfg[CFG_MODE_LSB +: MODE_W]);
         end
         if (newCfg[CFG_LIMIT_LSB +: LIMIT_W] >= LIMIT_MIN &&
             newCfg[CFG_LIMIT_LSB +: LIMIT_W] <= LIMIT_MAX) begin
            cfg_q.limit <= newCfg[CFG_LIMIT_LSB +: LIMIT_W];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         coil_q <= COIL_RST;
      end else if (wbWr && wb_adr_i == REG_COIL) begin
         coil_q.arm <= newCoil[COIL_ARM_BIT];
         coil_q.ack <= newCoil[COIL_ACK_BIT];
         coil_q.gate <= newCoil[COIL_GATE_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wbAck_q <= 1'b0;
         wbDat_q <= '0;
      end else begin
         wbAck_q <= wbReq;
         if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
               REG_CFG: wbDat_q <= cfgWord;
               REG_COIL: wbDat_q <= coilWord;
               REG_STAT: wbDat_q <= statWord;
               REG_RATE: wbDat_q <= DATA_W'(rate_q);
               REG_DIAG: wbDat_q <= DATA_W'(diag_q);
               default: wbDat_q <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // measurement; the gate runs free, so the first window after arming
   // is partial and may read low
   assign pinVec = {sensorInputB, sensorInputA};
   assign clearCnt = (state_q == ST_IDLE) || (state_q == ST_ARM);

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      zsm_rate_channel #(.RATE_W(RATE_W)) u_ch (
         .core_clk(core_clk),
         .reset_n(reset_n),
         .pinIn(pinVec[i]),
         .clear(clearCnt),
         .gateTick(gateTick_q),
         .level(lvl[i]),
         .rise(rise[i]),
         .rateHz(chRate[i])
      );
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gateCnt_q <= '0;
         gateTick_q <= 1'b0;
         rateTick_q <= 1'b0;
      end else begin
         gateTick_q <= (gateCnt_q == GCW'(GATE_CYCLES - 1));
         rateTick_q <= gateTick_q;
         if (gateCnt_q == GCW'(GATE_CYCLES - 1)) begin
            gateCnt_q <= '0;
         end else begin
            gateCnt_q <= gateCnt_q + 1'b1;
         end
      end
   end

   assign measRate = (chRate[0] > chRate[1]) ? chRate[0] : chRate[1];
   assign absDiff = (chRate[0] > chRate[1]) ? chRate[0] - chRate[1]
                                            : chRate[1] - chRate[0];
   assign rateScaled = PW'(measRate) * PW'(HYST_DEN);
   assign limitScaled = PW'(cfg_q.limit) * PW'(HYST_NUM);
   assign overLimit = measRate > RATE_W'(cfg_q.limit);
   assign belowHyst = rateScaled <= limitScaled;

   ////////////////////////////////////////////////////////////////////////
   // fault detection
   assign active = ~cfg_q.gateNeeded | coil_q.gate;
   assign running = active & coil_q.arm & (state_q inside
                    {ST_RISE, ST_FALL, ST_MEAS, ST_STILL});
   assign ackRise = coil_q.ack & ~ackPrev_q;
   assign ackFall = ~coil_q.ack & ackPrev_q;
   // the limit sits above the pulse ceiling the controller must honour
   assign overRange = measRate > RATE_OVER_HZ;
   // only both low is a break; both high is a legal stopped shaft
   assign openCkt = firstEdge_q & ~lvl[0] & ~lvl[1];
   assign noPulse = rateTick_q & ((chRate[0] == '0) != (chRate[1] == '0));
   assign diffRate = rateTick_q & (chRate[0] != '0) & (chRate[1] != '0) &
                     (absDiff > RATE_TOL_HZ);
   assign lockstep = firstEdge_q & rise[0] & rise[1];
   assign startAck = (state_q == ST_ARM) & active & coil_q.arm &
                     coil_q.ack & (cfg_q.mode != RS_AUTO);

   always_comb begin
      codeNow = DG_NOGATE;
      if (startAck) begin
         codeNow = DG_ACKSTART;
      end else if (running) begin
         if (overRange) begin
            codeNow = DG_OVER;
         end else if (openCkt) begin
            codeNow = DG_OPEN;
         end else if (noPulse) begin
            codeNow = DG_NOPULSE;
         end else if (diffRate || lockstep) begin
            codeNow = DG_DIFF;
         end
      end
   end

   assign faultHit = codeNow != DG_NOGATE;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         faultCode_q <= DG_NOGATE;
      end else if (faultHit && state_q != ST_FAULT) begin
         faultCode_q <= codeNow;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         firstEdge_q <= 1'b0;
      end else if (clearCnt) begin
         firstEdge_q <= 1'b0;
      end else if (running && rise != '0) begin
         firstEdge_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ackPrev_q <= 1'b0;
         ackDone_q <= 1'b0;
      end else begin
         ackPrev_q <= coil_q.ack;
         if (state_q == ST_FALL && ackFall) begin
            ackDone_q <= 1'b1;
         end else if (state_q != ST_MEAS) begin
            ackDone_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // restart sequencing; a fault holds until arm, or a needed gate, is withdrawn
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
      end else if (!active) begin
         state_q <= ST_IDLE;
      end else if (!coil_q.arm) begin
         state_q <= ST_ARM;
      end else begin
         unique case (state_q)
            ST_IDLE: state_q <= ST_ARM;
            ST_ARM: begin
               if (startAck) begin
                  state_q <= ST_FAULT;
               end else if (cfg_q.mode == RS_AUTO) begin
                  state_q <= ST_STILL;
               end else begin
                  state_q <= ST_RISE;
               end
            end
            ST_RISE: begin
               if (faultHit) begin
                  state_q <= ST_FAULT;
               end else if (ackRise) begin
                  state_q <= ST_FALL;
               end
            end
            ST_FALL: begin
               if (faultHit) begin
                  state_q <= ST_FAULT;
               end else if (ackFall) begin
                  state_q <= belowHyst ? ST_STILL : ST_MEAS;
               end
            end
            ST_MEAS: begin
               if (faultHit) begin
                  state_q <= ST_FAULT;
               end else if (belowHyst) begin
                  if (cfg_q.mode == RS_AUTO || ackDone_q) begin
                     state_q <= ST_STILL;
                  end else begin
                     state_q <= ST_RISE;
                  end
               end
            end
            ST_STILL: begin
               if (faultHit) begin
                  state_q <= ST_FAULT;
               end else if (overLimit) begin
                  state_q <= ST_MEAS;
               end
            end
            ST_FAULT: state_q <= ST_FAULT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs lag the state by one cycle so they all come from flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         release_q <= 1'b0;
         fault_q <= 1'b0;
         rate_q <= '0;
      end else begin
         release_q <= state_q == ST_STILL;
         fault_q <= state_q == ST_FAULT;
         rate_q <= measRate;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         diag_q <= DG_NOGATE;
      end else begin
         unique case (state_q)
            ST_IDLE: diag_q <= DG_NOGATE;
            ST_ARM: diag_q <= DG_WAIT_ARM;
            ST_RISE: diag_q <= DG_ACK_RISE;
            ST_FALL: diag_q <= DG_ACK_FALL;
            ST_MEAS: diag_q <= DG_MEASURE;
            ST_STILL: diag_q <= DG_STILL;
            ST_FAULT: diag_q <= faultCode_q;
         endcase
      end
   end

   assign wb_dat_o = wbDat_q;
   assign wb_ack_o = wbAck_q;
   assign standstillRelease = release_q;
   assign faultFlag = fault_q;
   assign actualRateHz = rate_q;
   assign diagWord = diag_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_gate;
      cfg_q.gateNeeded && !coil_q.gate |=> state_q == ST_IDLE ##1
         diag_q == DG_NOGATE;
   endproperty
   a_gate: assert property (p_gate)
      else $error("ungated block not idle");

   property p_unarmed;
      active && !coil_q.arm |-> ##2 !release_q;
   endproperty
   a_unarmed: assert property (p_unarmed)
      else $error("release while unarmed");

   property p_auto_entry;
      state_q == ST_ARM && active && coil_q.arm &&
         cfg_q.mode == RS_AUTO |-> ##2 release_q;
   endproperty
   a_auto_entry: assert property (p_auto_entry)
      else $error("auto start gave no release");

   property p_open;
      running && openCkt && !overRange |=> state_q == ST_FAULT ##1
         (fault_q && !release_q && diag_q == DG_OPEN);
   endproperty
   a_open: assert property (p_open)
      else $error("open circuit not flagged");

   property p_over;
      running && overRange |=> state_q == ST_FAULT &&
         faultCode_q == DG_OVER;
   endproperty
   a_over: assert property (p_over)
      else $error("overrange not flagged");

   property p_ack_start;
      startAck |=> state_q == ST_FAULT ##1 diag_q == DG_ACKSTART;
   endproperty
   a_ack_start: assert property (p_ack_start)
      else $error("ack at startup not flagged");

   property p_trip;
      state_q == ST_STILL && overLimit && !faultHit && active &&
         coil_q.arm |=> state_q == ST_MEAS ##1 !release_q;
   endproperty
   a_trip: assert property (p_trip)
      else $error("release kept above limit");

   property p_manual_return;
      $rose(release_q) && cfg_q.mode != RS_AUTO |->
         $past(state_q, 2) inside {ST_FALL, ST_MEAS};
   endproperty
   a_manual_return: assert property (p_manual_return)
      else $error("manual release without ack");

   property p_auto_return;
      state_q == ST_MEAS && cfg_q.mode == RS_AUTO && belowHyst &&
         !faultHit && active && coil_q.arm |-> ##2 release_q;
   endproperty
   a_auto_return: assert property (p_auto_return)
      else $error("auto release did not return");

   property p_fault_hold;
      state_q == ST_FAULT && active && coil_q.arm |=>
         state_q == ST_FAULT ##1 fault_q;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault cleared while armed");

   property p_limit_range;
      cfg_q.limit >= LIMIT_MIN && cfg_q.limit <= LIMIT_MAX;
   endproperty
   a_limit_range: assert property (p_limit_range)
      else $error("limit out of range");

   c_still: cover property (state_q == ST_MEAS ##1 state_q == ST_STILL);
   c_open: cover property (fault_q && diag_q == DG_OPEN);
   c_manual: cover property (state_q == ST_FALL ##1 state_q == ST_STILL);
   c_trip: cover property (release_q ##1 !release_q && !fault_q);
endmodule

/* File: verilog/zsm_pkg.sv */
package zsm_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int MS_PER_S = 1000;
   localparam int GATE_TIME_MS = 1000;
   localparam int GATE_CYCLES_DFLT = CLK_HZ / MS_PER_S * GATE_TIME_MS;
   localparam int RATE_W_DFLT = 16;
   localparam int LIMIT_W = 6;
   localparam int MODE_W = 2;
   localparam int DIAG_W = 16;
   localparam int HYST_W = 5;
   localparam int DATA_W = 32;
   localparam int SEL_W = 4;
   localparam int LANE_W = 8;
   localparam int ADDR_W = 5;
   localparam int NUM_CH = 2;

   localparam logic [LIMIT_W-1:0] LIMIT_MIN = 6'h02;
   localparam logic [LIMIT_W-1:0] LIMIT_MAX = 6'h32;
   localparam logic [LIMIT_W-1:0] LIMIT_RST = 6'h02;
   localparam logic [15:0] RATE_OVER_HZ = 16'h04b0;
   localparam logic [15:0] RATE_TOL_HZ = 16'h0001;
   localparam logic [HYST_W-1:0] HYST_NUM = 5'h13;
   localparam logic [HYST_W-1:0] HYST_DEN = 5'h14;

   localparam logic [ADDR_W-1:0] REG_CFG = 5'h00;
   localparam logic [ADDR_W-1:0] REG_COIL = 5'h04;
   localparam logic [ADDR_W-1:0] REG_STAT = 5'h08;
   localparam logic [ADDR_W-1:0] REG_RATE = 5'h0c;
   localparam logic [ADDR_W-1:0] REG_DIAG = 5'h10;

   localparam int CFG_GATE_BIT = 0;
   localparam int CFG_MODE_LSB = 1;
   localparam int CFG_LIMIT_LSB = 8;
   localparam int COIL_ARM_BIT = 0;
   localparam int COIL_ACK_BIT = 1;
   localparam int COIL_GATE_BIT = 2;
   localparam int STAT_REL_BIT = 0;
   localparam int STAT_FLT_BIT = 1;
   localparam int STAT_EDGE_BIT = 2;

   localparam logic [DIAG_W-1:0] DG_NOGATE = 16'h0000;
   localparam logic [DIAG_W-1:0] DG_WAIT_ARM = 16'h2001;
   localparam logic [DIAG_W-1:0] DG_ACK_RISE = 16'h2003;
   localparam logic [DIAG_W-1:0] DG_ACK_FALL = 16'h2004;
   localparam logic [DIAG_W-1:0] DG_MEASURE = 16'h2009;
   localparam logic [DIAG_W-1:0] DG_STILL = 16'h8010;
   localparam logic [DIAG_W-1:0] DG_OPEN = 16'hf007;
   localparam logic [DIAG_W-1:0] DG_OVER = 16'hf008;
   localparam logic [DIAG_W-1:0] DG_DIFF = 16'hf009;
   localparam logic [DIAG_W-1:0] DG_NOPULSE = 16'hf00a;
   localparam logic [DIAG_W-1:0] DG_ACKSTART = 16'hf013;

   typedef enum logic [MODE_W-1:0] {
      RS_AUTO = 2'h0,
      RS_MANUAL = 2'h1,
      RS_SUPER = 2'h2
   } restart_e;

   typedef struct packed {
      logic [LIMIT_W-1:0] limit;
      restart_e mode;
      logic gateNeeded;
   } cfg_s;

   typedef struct packed {
      logic gate;
      logic ack;
      logic arm;
   } coils_s;

   localparam cfg_s CFG_RST = '{limit: LIMIT_RST, mode: RS_MANUAL,
                                gateNeeded: 1'b0};
   localparam coils_s COIL_RST = '{gate: 1'b0, ack: 1'b0, arm: 1'b0};
endpackage

/* File: verilog/zsm_rate_channel.sv */
`timescale 1ns/1ps
module zsm_rate_channel
   import zsm_pkg::*;
#(
   parameter int RATE_W = RATE_W_DFLT
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pinIn,
   input wire logic clear,
   input wire logic gateTick,
   output logic level,
   output logic rise,
   output logic [RATE_W-1:0] rateHz
);
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic level_q;
   logic rise_q;
   logic levelNew;
   logic [RATE_W-1:0] count_q;
   logic [RATE_W-1:0] rate_q;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= pinIn;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // a level counts only once the last two stages agree
   assign levelNew = (sync2_q == sync3_q) ? sync3_q : level_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         level_q <= levelNew;
         rise_q <= levelNew & ~level_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rising edges per gate window; a one second window gives 1 hz steps
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= '0;
         rate_q <= '0;
      end else if (clear) begin
         count_q <= '0;
         rate_q <= '0;
      end else if (gateTick) begin
         rate_q <= count_q;
         count_q <= RATE_W'(rise_q);
      end else if (rise_q && count_q != '1) begin
         count_q <= count_q + 1'b1;
      end
   end

   assign level = level_q;
   assign rise = rise_q;
   assign rateHz = rate_q;

   ////////////////////////////////////////////////////////////////////////
   property p_rate_steps;
      @(posedge core_clk) disable iff (!reset_n)
      $changed(rate_q) |-> $past(gateTick) || $past(clear);
   endproperty
   a_rate_steps: assert property (p_rate_steps)
      else $error("rate changed outside a gate tick");

   property p_rate_clear;
      @(posedge core_clk) disable iff (!reset_n)
      clear |=> rate_q == '0 && count_q == '0;
   endproperty
   a_rate_clear: assert property (p_rate_clear)
      else $error("rate not cleared");
endmodule
